// ===== hdl/syt_consts.svh
// constants for the system timer: register offsets, fields, reset values, counts
// assumes a 32-bit apb slave and a slow clock sampled on the bus clock
//
// Operation
// (RL1) watchdog load value 0 gives 65536 times 128 slow clock cycles
// (RL2) overflow raises an internal reset request only when reset enable is set
// (RL3) overflow drives the overflow pin low 8 slow cycles only when enabled
// (RL4) prescale value sets slow cycles per seconds increment, 0 means 65536
// (RL5) status bit 0 sets when the periodic counter reaches zero, read clears
// (RL6) status bit 1 sets when the watchdog reaches zero, read clears
// (RL7) status bit 2 sets on every seconds counter increment, read clears
// (RL8) status bit 3 sets when seconds counter equals alarm value, read clears
// (RL9) writing ones to interrupt enable sets matching mask bits, zeros ignored
// (RL10) writing ones to interrupt disable clears matching mask bits, zeros ignored
// (RL11) mask register reads one per enabled source, zero per disabled source
// (RL12) alarm value compares with the seconds counter, 0 matches at rollover
// (RL13) current value register returns the 20-bit counter, upper bits zero
// (RL14) writing period mode reloads and restarts periodic counter; zero reloads automatically
// (RL15) watchdog restart reloads watchdog counter and resets the divide-by-128 prescaler
// (RL16) writing watchdog mode does not reload; overflow reloads and restarts itself
// (RL17) writing prescale mode reloads the prescaler and clears the seconds counter
// (RL18) interrupt output high while any status bit and its mask bit are set
// (RL19) slow events cross safely and an event during a status read survives
`ifndef SYT_CONSTS_SVH
`define SYT_CONSTS_SVH

`define SYT_ADDR_W 8
`define SYT_OFS_CTRL 8'h00
`define SYT_OFS_PERIOD 8'h04
`define SYT_OFS_WDMODE 8'h08
`define SYT_OFS_RTMODE 8'h0c
`define SYT_OFS_STATUS 8'h10
`define SYT_OFS_IEN 8'h14
`define SYT_OFS_IDIS 8'h18
`define SYT_OFS_IMASK 8'h1c
`define SYT_OFS_ALARM 8'h20
`define SYT_OFS_CURRENT 8'h24

`define SYT_CTRL_RESTART 0
`define SYT_WD_OVERFLOW_RESET_ENABLE_BIT 16
`define SYT_WD_OVERFLOW_OUTPUT_ENABLE_BIT 17
`define SYT_SR_PERIOD 0
`define SYT_SR_WDOG 1
`define SYT_SR_TICK 2
`define SYT_SR_ALARM 3
`define SYT_NSRC 4

`define SYT_PERIOD_RST 16'h0000
`define SYT_WDV_RST 16'h0000
`define SYT_OVERFLOW_RESET_ENABLE_RST 1'b0
`define SYT_OVERFLOW_OUTPUT_ENABLE_RST 1'b1
`define SYT_REALTIME_PRESCALE_RST 16'h8000
`define SYT_ALARM_RST 20'h00000

`define SYT_WD_DIVIDE 128
`define SYT_EXT_LOW_TICKS 4'h8

`endif

// ===== hdl/syt_pkg.sv
// types for the system timer state
// assumes syt_consts.svh on the include path
`include "syt_consts.svh"

package syt_pkg;

    typedef struct packed {
        logic [15:0] pit_load;
        logic [15:0] pit_cnt;
        logic [15:0] wd_load;
        logic wd_overflow_reset_enable;
        logic wd_overflow_output_enable;
        logic [15:0] wd_cnt;
        logic [15:0] wd_div;
        logic [3:0] ext_cnt;
        logic [15:0] rt_pres;
        logic [15:0] rt_div;
        logic [19:0] rt_cnt;
        logic [19:0] alarm;
        logic [3:0] status;
        logic [3:0] mask;
        logic [3:0] rd_flags;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic ovf_pin_n;
        logic wd_reset_req;
    } syt_state_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic tick;
    } syt_tick_state_type;

endpackage

// ===== hdl/syt_tick_if.sv
// carries the one-cycle slow clock tick from the sampler to the timer core
// assumes both ends run on the bus clock
`timescale 1ns/1ps
`default_nettype none

interface syt_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

`default_nettype wire

// ===== hdl/syt_slow_tick.sv
// samples the slow clock pin and emits one bus clock pulse per rising edge
// assumes the slow clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none

module syt_slow_tick
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // slow clock pin
    input wire logic slow_clock,
    // tick out
    syt_tick_if.src tick_if
);

    syt_pkg::syt_tick_state_type st;
    syt_pkg::syt_tick_state_type next_st;

    // s1 is only read by s2; an edge counts once s2 and s3 agree
    always_comb
    begin
        next_st = st;
        next_st.s1 = slow_clock;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.tick = 1'b0;
        if (st.s2 == st.s3 && st.s3 != st.level)
        begin
            next_st.level = st.s3;
            next_st.tick = st.s3;  // see (RL19)
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick_if.tick = st.tick;

endmodule

`default_nettype wire

// ===== hdl/syt_timer.sv
// system timer: periodic interval counter, watchdog and seconds counter with alarm
// assumes an apb master on clk and a slow clock pin far slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "syt_consts.svh"

module syt_timer
#(
    parameter int WD_DIVIDE = `SYT_WD_DIVIDE
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // slow clock pin
    input wire logic slow_clock,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SYT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system outputs
    output logic irq,
    output logic overflow_pin_n,
    output logic watchdog_reset_req
);

    if (WD_DIVIDE < 2 || WD_DIVIDE > 65536)
    begin : g_bad_divide
        $error("syt_timer: WD_DIVIDE must lie in 2..65536");
    end

    localparam logic [15:0] DIV_LAST = 16'(WD_DIVIDE - 1);

    localparam syt_pkg::syt_state_type RESET_ST = '{
        pit_load: `SYT_PERIOD_RST,
        pit_cnt: `SYT_PERIOD_RST,
        wd_load: `SYT_WDV_RST,
        wd_overflow_reset_enable: `SYT_OVERFLOW_RESET_ENABLE_RST,
        wd_overflow_output_enable: `SYT_OVERFLOW_OUTPUT_ENABLE_RST,
        wd_cnt: `SYT_WDV_RST,
        wd_div: 16'h0000,
        ext_cnt: 4'h0,
        rt_pres: `SYT_REALTIME_PRESCALE_RST,
        rt_div: `SYT_REALTIME_PRESCALE_RST,
        rt_cnt: 20'h00000,
        alarm: `SYT_ALARM_RST,
        status: 4'h0,
        mask: 4'h0,
        rd_flags: 4'h0,
        prdata: 32'h00000000,
        pready: 1'b0,
        pslverr: 1'b0,
        irq: 1'b0,
        ovf_pin_n: 1'b1,
        wd_reset_req: 1'b0
    };

    syt_pkg::syt_state_type st;
    syt_pkg::syt_state_type next_st;

    syt_tick_if tick_if ();

    syt_slow_tick u_tick
    (
        .clk(clk),
        .srst(srst),
        .slow_clock(slow_clock),
        .tick_if(tick_if)
    );

    logic tick;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic [3:0] events;
    logic wd_ovf;
    logic [31:0] rd_mux;

    assign tick = tick_if.tick;
    assign setup = psel & ~penable;
    assign access = psel & penable & st.pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;

    // read data is sampled in the setup cycle so the answer can leave a flip-flop
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        unique case (paddr)
            `SYT_OFS_CTRL, `SYT_OFS_IEN, `SYT_OFS_IDIS:
                rd_mux = 32'h00000000;
            `SYT_OFS_PERIOD:
                rd_mux = {16'h0000, st.pit_load};
            `SYT_OFS_WDMODE:
                rd_mux = {14'h0000, st.wd_overflow_output_enable, st.wd_overflow_reset_enable, st.wd_load};
            `SYT_OFS_RTMODE:
                rd_mux = {16'h0000, st.rt_pres};
            `SYT_OFS_STATUS:
                rd_mux = {28'h0000000, st.status};
            `SYT_OFS_IMASK:
                rd_mux = {28'h0000000, st.mask};  // see (RL11)
            `SYT_OFS_ALARM:
                rd_mux = {12'h000, st.alarm};
            `SYT_OFS_CURRENT:
                rd_mux = {12'h000, st.rt_cnt};  // see (RL13)
            default:
                mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        next_st = st;
        events = 4'h0;
        wd_ovf = 1'b0;

        // periodic interval counter; a load of zero wraps through 65536 ticks
        if (tick)
        begin
            if (st.pit_cnt == 16'h0001)
            begin
                next_st.pit_cnt = st.pit_load;  // see (RL14)
                events[`SYT_SR_PERIOD] = 1'b1;  // see (RL5)
            end
            else
            begin
                next_st.pit_cnt = st.pit_cnt - 16'h0001;
            end
        end

        // watchdog: divider then down counter, zero load gives the longest period
        if (tick)
        begin
            if (st.wd_div == DIV_LAST)
            begin
                next_st.wd_div = 16'h0000;
                if (st.wd_cnt == 16'h0001)
                begin
                    wd_ovf = 1'b1;
                    next_st.wd_cnt = st.wd_load;  // see (RL16)
                end
                else
                begin
                    next_st.wd_cnt = st.wd_cnt - 16'h0001;  // see (RL1)
                end
            end
            else
            begin
                next_st.wd_div = st.wd_div + 16'h0001;
            end
        end
        events[`SYT_SR_WDOG] = wd_ovf;  // see (RL6)

        // overflow pin low for a fixed number of slow ticks
        if (tick && st.ext_cnt != 4'h0)
        begin
            next_st.ext_cnt = st.ext_cnt - 4'h1;
        end
        if (wd_ovf && st.wd_overflow_output_enable)
        begin
            next_st.ext_cnt = `SYT_EXT_LOW_TICKS;  // see (RL3)
        end

        // seconds counter with prescaler and alarm compare
        if (tick)
        begin
            if (st.rt_div == 16'h0001)
            begin
                next_st.rt_div = st.rt_pres;  // see (RL4)
                next_st.rt_cnt = st.rt_cnt + 20'h00001;
                events[`SYT_SR_TICK] = 1'b1;  // see (RL7)
                if (st.rt_cnt + 20'h00001 == st.alarm)
                begin
                    events[`SYT_SR_ALARM] = 1'b1;  // see (RL8) (RL12)
                end
            end
            else
            begin
                next_st.rt_div = st.rt_div - 16'h0001;
            end
        end

        // register writes win over a tick in the same cycle
        if (wr)
        begin
            unique case (paddr)
                `SYT_OFS_CTRL:
                    if (pwdata[`SYT_CTRL_RESTART])
                    begin
                        next_st.wd_cnt = st.wd_load;  // see (RL15)
                        next_st.wd_div = 16'h0000;
                    end
                `SYT_OFS_PERIOD:
                begin
                    next_st.pit_load = pwdata[15:0];
                    next_st.pit_cnt = pwdata[15:0];  // see (RL14)
                end
                `SYT_OFS_WDMODE:
                begin
                    next_st.wd_load = pwdata[15:0];  // see (RL16)
                    next_st.wd_overflow_reset_enable = pwdata[`SYT_WD_OVERFLOW_RESET_ENABLE_BIT];
                    next_st.wd_overflow_output_enable = pwdata[`SYT_WD_OVERFLOW_OUTPUT_ENABLE_BIT];
                end
                `SYT_OFS_RTMODE:
                begin
                    next_st.rt_pres = pwdata[15:0];
                    next_st.rt_div = pwdata[15:0];  // see (RL17)
                    next_st.rt_cnt = 20'h00000;
                end
                `SYT_OFS_IEN:
                    next_st.mask = st.mask | pwdata[`SYT_NSRC-1:0];  // see (RL9)
                `SYT_OFS_IDIS:
                    next_st.mask = st.mask & ~pwdata[`SYT_NSRC-1:0];  // see (RL10)
                `SYT_OFS_ALARM:
                    next_st.alarm = pwdata[19:0];
                default:
                    next_st.alarm = st.alarm;
            endcase
        end

        // a read clears only the bits it reported; a new event is kept
        if (rd && paddr == `SYT_OFS_STATUS)
        begin
            next_st.status = (st.status & ~st.rd_flags) | events;  // see (RL19)
        end
        else
        begin
            next_st.status = st.status | events;  // see (RL5) (RL6) (RL7) (RL8)
        end

        // bus answer, always one wait-free access cycle
        next_st.pready = setup;
        next_st.pslverr = setup & ~mapped;
        if (setup)
        begin
            next_st.prdata = pwrite ? 32'h00000000 : rd_mux;
            next_st.rd_flags = (!pwrite && paddr == `SYT_OFS_STATUS) ? st.status : 4'h0;
        end

        next_st.irq = |(next_st.status & next_st.mask);  // see (RL18)
        next_st.ovf_pin_n = (next_st.ext_cnt == 4'h0);  // see (RL3)
        next_st.wd_reset_req = wd_ovf & st.wd_overflow_reset_enable;  // see (RL2)
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= RESET_ST;
        else
            st <= next_st;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
    assign overflow_pin_n = st.ovf_pin_n;
    assign watchdog_reset_req = st.wd_reset_req;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_wd_last;
        tick && st.wd_div == DIV_LAST && st.wd_cnt == 16'h0001;
    endsequence

    sequence s_no_restart;
        !(wr && paddr == `SYT_OFS_CTRL);
    endsequence

    a_pit_reload_flag: assert property (  // see (RL5) (RL14)
        tick && st.pit_cnt == 16'h0001 && !(wr && paddr == `SYT_OFS_PERIOD)
        |=> st.pit_cnt == $past(st.pit_load) && st.status[`SYT_SR_PERIOD])
        else $error("periodic reload or flag missing");

    a_wd_overflow: assert property (  // see (RL6) (RL16)
        s_wd_last ##0 s_no_restart
        |=> st.wd_cnt == $past(st.wd_load) && st.status[`SYT_SR_WDOG] && st.wd_div == 16'h0000)
        else $error("watchdog overflow handling wrong");

    a_wd_reset_gate: assert property (  // see (RL2)
        s_wd_last |=> watchdog_reset_req == $past(st.wd_overflow_reset_enable))
        else $error("reset request does not follow enable");

    a_ext_low_start: assert property (  // see (RL3)
        $fell(overflow_pin_n) |-> $past(st.wd_overflow_output_enable) && st.ext_cnt == `SYT_EXT_LOW_TICKS)
        else $error("overflow pin fell without enable");

    a_ext_idle_high: assert property (  // see (RL3)
        st.ext_cnt == 4'h0 |-> overflow_pin_n)
        else $error("overflow pin low while idle");

    a_wd_restart: assert property (  // see (RL15)
        wr && paddr == `SYT_OFS_CTRL && pwdata[`SYT_CTRL_RESTART]
        |=> st.wd_cnt == $past(st.wd_load) && st.wd_div == 16'h0000)
        else $error("watchdog restart did not reload");

    a_wdmode_no_load: assert property (  // see (RL16)
        wr && paddr == `SYT_OFS_WDMODE && !tick |=> $stable(st.wd_cnt))
        else $error("watchdog mode write reloaded the counter");

    a_rtmode_clear: assert property (  // see (RL17)
        wr && paddr == `SYT_OFS_RTMODE |=> st.rt_cnt == 20'h00000 && st.rt_div == st.rt_pres)
        else $error("prescale write did not restart");

    a_mask_set_clear: assert property (  // see (RL9) (RL10)
        wr && (paddr == `SYT_OFS_IEN || paddr == `SYT_OFS_IDIS)
        |=> st.mask == ($past(paddr) == `SYT_OFS_IEN
            ? ($past(st.mask) | $past(pwdata[`SYT_NSRC-1:0]))
            : ($past(st.mask) & ~$past(pwdata[`SYT_NSRC-1:0]))))
        else $error("mask update wrong");

    a_irq_level: assert property (  // see (RL18)
        irq == |(st.status & st.mask))
        else $error("interrupt output disagrees with status and mask");

    a_status_sticky: assert property (  // see (RL19)
        st.status[`SYT_SR_TICK] && !(rd && paddr == `SYT_OFS_STATUS)
        |=> st.status[`SYT_SR_TICK])
        else $error("status bit lost without a read");

    a_rt_increment: assert property (  // see (RL7) (RL12)
        tick && st.rt_div == 16'h0001 && !wr
        |=> st.rt_cnt == $past(st.rt_cnt) + 20'h00001 && st.status[`SYT_SR_TICK]
            && (st.rt_cnt != st.alarm || st.status[`SYT_SR_ALARM]))
        else $error("seconds increment or alarm wrong");

    a_current_upper: assert property (  // see (RL13)
        setup && !pwrite && paddr == `SYT_OFS_CURRENT |=> prdata[31:20] == 12'h000 && pready)
        else $error("current value upper bits not zero");

endmodule

`default_nettype wire

// ===== test/syt_timer_test.sv
// self-checking bench for the system timer: apb register tasks and directed tests
// assumes syt_consts.svh on the include path and the design's watchdog divider parameter
`timescale 1ns/1ps
`default_nettype none
`include "syt_consts.svh"

module syt_timer_test;
    localparam int WDIV = 4;
    logic clk, srst, psel, penable, pwrite;
    logic slow_clock = 1'b0;
    logic [`SYT_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, overflow_pin_n, watchdog_reset_req, err;
    logic [2:0] sdiv = 3'h0;
    int failures, n_checks, n, m;
    int req_cnt = 0;
    int low_cnt = 0;

    syt_timer #(.WD_DIVIDE(WDIV)) i_syt_timer
    (
        .clk(clk), .srst(srst), .slow_clock(slow_clock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .overflow_pin_n(overflow_pin_n),
        .watchdog_reset_req(watchdog_reset_req)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // slow clock at clk/8: one tick every 8 cycles keeps the counts short
    always @(posedge clk)
    begin
        sdiv <= sdiv + 3'h1;
        slow_clock <= sdiv[2];
        if (srst === 1'b0 && overflow_pin_n === 1'b0)
            low_cnt <= low_cnt + 1;
        if (srst === 1'b0 && watchdog_reset_req === 1'b1)
            req_cnt <= req_cnt + 1;
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50)
            chk(32'h0, 32'h1, "pready never came");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp, "read value");
        chk({31'h0, err}, 32'h0, "unexpected slave error");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        $display("CHECK FAILED at %0t: bench timeout", $time);
        failures++;
        give_verdict();
    end

    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        failures = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // reset values and access kinds
        rdc(`SYT_OFS_PERIOD, 32'hffffffff, 32'h0);
        rdc(`SYT_OFS_WDMODE, 32'hffffffff, 32'h00020000);
        rdc(`SYT_OFS_RTMODE, 32'hffffffff, 32'h00008000);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'h0);
        rdc(`SYT_OFS_ALARM, 32'hffffffff, 32'h0);
        rdc(`SYT_OFS_IEN, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped address not refused");
        chk({30'h0, irq, overflow_pin_n}, 32'h1, "idle outputs");
        // mask set and clear, zeros leave bits alone
        wr(`SYT_OFS_IEN, 32'h5);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'h5);
        wr(`SYT_OFS_IEN, 32'ha);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'hf);
        wr(`SYT_OFS_IDIS, 32'h3);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'hc);
        wr(`SYT_OFS_IDIS, 32'h0);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'hc);
        wr(`SYT_OFS_IDIS, 32'hf);
        wr(`SYT_OFS_IEN, 32'h1);
        wr(`SYT_OFS_IMASK, 32'hf);
        rdc(`SYT_OFS_IMASK, 32'hffffffff, 32'h1);
        // periodic counter of 6 ticks, about 48 cycles
        wr(`SYT_OFS_PERIOD, 32'h6);
        repeat (20) @(posedge clk);
        rdc(`SYT_OFS_STATUS, 32'h1, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq before period end");
        repeat (50) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq after period end");
        rdc(`SYT_OFS_STATUS, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq after status read");
        rdc(`SYT_OFS_STATUS, 32'h1, 32'h0);
        wr(`SYT_OFS_PERIOD, 32'h0);
        wr(`SYT_OFS_IDIS, 32'h1);
        // watchdog load 3 with both enables: 12 ticks apart, so the 8-tick low span ends first
        wr(`SYT_OFS_WDMODE, 32'h00030003);
        wr(`SYT_OFS_CTRL, 32'h1);
        n = 0;
        while (watchdog_reset_req !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, (n >= 88 && n <= 100)}, 32'h1, "watchdog overflow time");
        // a mode write must not reload the running count
        wr(`SYT_OFS_WDMODE, 32'h00030100);
        n = 0;
        while (overflow_pin_n !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, (low_cnt >= 56 && low_cnt <= 72)}, 32'h1, "pin low span");
        n = 0;
        while (watchdog_reset_req !== 1'b1 && n < 120)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, (n < 120)}, 32'h1, "no reload after overflow");
        rdc(`SYT_OFS_STATUS, 32'h2, 32'h2);
        wr(`SYT_OFS_CTRL, 32'h1);
        n = req_cnt;
        repeat (300) @(posedge clk);
        chk(req_cnt - n, 32'h0, "restart picks up new load");
        // enables off: overflow sets status only
        wr(`SYT_OFS_WDMODE, 32'h00000002);
        wr(`SYT_OFS_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        n = req_cnt;
        m = low_cnt;
        rdc(`SYT_OFS_STATUS, 32'h2, 32'h0);
        repeat (100) @(posedge clk);
        chk(req_cnt - n, 32'h0, "reset request while disabled");
        chk(low_cnt - m, 32'h0, "pin low while disabled");
        rdc(`SYT_OFS_STATUS, 32'h2, 32'h2);
        // seconds counter: prescale 2, alarm at 3
        wr(`SYT_OFS_IEN, 32'h8);
        wr(`SYT_OFS_ALARM, 32'h00000003);
        rdc(`SYT_OFS_ALARM, 32'hffffffff, 32'h3);
        wr(`SYT_OFS_RTMODE, 32'h2);
        rdc(`SYT_OFS_CURRENT, 32'hffffffff, 32'h0);
        repeat (26) @(posedge clk);
        rdc(`SYT_OFS_STATUS, 32'hc, 32'h4);
        repeat (40) @(posedge clk);
        apb(1'b0, `SYT_OFS_CURRENT, 32'h0);
        chk({31'h0, (rd >= 32'h3 && rd <= 32'h6)}, 32'h1, "seconds count");
        chk(rd & 32'hfff00000, 32'h0, "upper bits of count");
        chk({31'h0, irq}, 32'h1, "irq on alarm");
        rdc(`SYT_OFS_STATUS, 32'hc, 32'hc);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq after alarm read");
        rdc(`SYT_OFS_STATUS, 32'h8, 32'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
